// ===== hw/adcsq_pkg.sv
// Package with register map, field layout and timing for the converter control.
package adcsq_pkg;
    // Register byte addresses.
    localparam logic [15:0] ADDR_RESULT_A   = 16'hFFE0;
    localparam logic [15:0] ADDR_RESULT_B   = 16'hFFE2;
    localparam logic [15:0] ADDR_RESULT_C   = 16'hFFE4;
    localparam logic [15:0] ADDR_RESULT_D   = 16'hFFE6;
    localparam logic [15:0] ADDR_CTRL_STAT  = 16'hFFE8;
    localparam logic [15:0] ADDR_TRIG_CTRL  = 16'hFFEA;
    // Control/status and trigger control field positions.
    localparam int BIT_DONE      = 7;
    localparam int BIT_IRQ_EN    = 6;
    localparam int BIT_START     = 5;
    localparam int BIT_SCAN      = 4;
    localparam int BIT_SPEED     = 3;
    localparam int BIT_GROUP     = 2;
    localparam int BIT_TRIG_EN   = 7;
    // Reset values.
    localparam logic [7:0] RESET_CTRL_STAT = 8'h00;
    localparam logic [7:0] RESET_TRIG_CTRL = 8'h7F;
    localparam logic [7:0] RESET_RESULT    = 8'h00;
    localparam logic [7:0] UNMAPPED_READ   = 8'h00;
    // Conversion time in device states for each speed setting.
    localparam int SLOW_STATES = 242;
    localparam int FAST_STATES = 122;
    // Fast-setting conversion time in ns at the 10 MHz reference clock.
    localparam real FAST_TIME_NS   = 12200.0;
    localparam real REF_PERIOD_NS  = 100.0;
    localparam real CLK_PERIOD_NS  = 25.0;
    // Cycles per device state at this clock.
    localparam int CYC_PER_STATE = int'(REF_PERIOD_NS / CLK_PERIOD_NS);
    // Cycles for one conversion at each speed.
    localparam int SLOW_CYCLES = SLOW_STATES * CYC_PER_STATE;
    localparam int FAST_CYCLES =
        int'(FAST_TIME_NS / CLK_PERIOD_NS) * 0 + FAST_STATES * CYC_PER_STATE;
    localparam int RES_BITS = 8;
    localparam int NUM_CH   = 8;
endpackage

// ===== hw/adcsq_sar.sv
// Successive-approximation engine for one 8-bit conversion.
`timescale 1ns/1ps
module adcsq_sar #(
    parameter int BITS = 8
) (
    // Clock and reset.
    input  wire logic            clk_in,
    input  wire logic            resetn_in,
    // Control.
    input  wire logic            abort_in,
    input  wire logic            go_in,
    input  wire logic [15:0]     step_cycles_in,
    // Comparator.
    input  wire logic            cmp_in,
    output logic [BITS-1:0]      trial_out,
    // Result.
    output logic                 done_out,
    output logic [BITS-1:0]      result_out
);
    logic [15:0]            tick;
    logic [$clog2(BITS):0]  bit_idx;
    logic                   active;

    // Each bit trial is held for one step interval before the comparator
    // is taken, so the total time tracks the selected conversion speed.
    always_ff @(posedge clk_in) begin
        if (!resetn_in || abort_in) begin
            active     <= 1'b0;
            tick       <= 16'h0000;
            bit_idx    <= '0;
            trial_out  <= '0;
            done_out   <= 1'b0;
            result_out <= '0;
        end else begin
            done_out <= 1'b0;
            if (!active) begin
                if (go_in) begin
                    active    <= 1'b1;
                    tick      <= 16'h0000;
                    bit_idx   <= ($clog2(BITS)+1)'(BITS - 1);
                    trial_out <= {1'b1, {(BITS-1){1'b0}}};
                end
            end else if (tick != step_cycles_in - 16'h0001) begin
                tick <= tick + 16'h0001;
            end else begin
                tick <= 16'h0000;
                if (!cmp_in) begin
                    trial_out[bit_idx[$clog2(BITS)-1:0]] <= 1'b0;
                end
                if (bit_idx == '0) begin
                    active     <= 1'b0;
                    done_out   <= 1'b1;
                    result_out <= cmp_in ? trial_out
                                         : (trial_out & ~BITS'(1));
                end else begin
                    bit_idx <= bit_idx - 1'b1;
                    trial_out[bit_idx[$clog2(BITS)-1:0] - 1'b1] <= 1'b1;
                end
            end
        end
    end
endmodule

// ===== hw/adcsq_top.sv
// Converter control: register file, sequencing, results and trigger.
`timescale 1ns/1ps
module adcsq_top #(
    parameter int SLOW_CYC = adcsq_pkg::SLOW_CYCLES,
    parameter int FAST_CYC = adcsq_pkg::FAST_CYCLES
) (
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        standby_in,
    // Register port.
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out,
    // Analog front end: comparator result for the current trial.
    input  wire logic        cmp_in,
    output logic      [2:0]  mux_sel_out,
    output logic      [7:0]  dac_trial_out,
    // External trigger, active low, and interrupt.
    input  wire logic        ext_start_trigger_n_in,
    output logic             conversion_end_irq_out
);
    typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_LAUNCH, ADCSQ_WAIT}
        adcsq_state_e;

    logic [7:0]   result_reg [4];
    logic         conversion_done_flag;
    logic         done_irq_enable;
    logic         conversion_start;
    logic         scan_mode;
    logic         conversion_speed_sel;
    logic [2:0]   channel_sel;
    logic         ext_trigger_enable;
    logic         done_seen;
    logic [2:0]   trig_sync;
    logic         trig_level;
    adcsq_state_e state;
    logic [1:0]   cur_ch;
    logic         sar_go;
    logic         sar_done;
    logic [7:0]   sar_result;
    logic [7:0]   sar_trial;
    logic         clr_all;
    logic         trig_fall;
    logic         ctrl_wr;
    logic         pass_end;
    logic         start_clr;
    logic         res_load;
    logic         scan_last;
    logic [15:0]  step_cycles;
    logic [7:0]   csr_image;
    logic [7:0]   next_rdata;

    // Register address decode, shared by read and write paths.
    function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
        return a == b;
    endfunction

    // Reset clears the block; standby clears all of it but the trigger synchronizer and read data.
    assign clr_all = !resetn_in || standby_in;
    assign ctrl_wr = wr_in && hit(addr_in, adcsq_pkg::ADDR_CTRL_STAT);

    // Trigger pin passes three flops; a change counts when the last two agree.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            trig_sync <= 3'h7;
        end else begin
            trig_sync <= {trig_sync[1:0], ext_start_trigger_n_in};
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            trig_level <= 1'b1;
        end else if (trig_sync[2] == trig_sync[1]) begin
            trig_level <= trig_sync[2];
        end
    end
    assign trig_fall = trig_level && (trig_sync[2] == trig_sync[1])
                       && !trig_sync[2] && ext_trigger_enable;

    // Channel finished by the engine while the sequencer waits for it.
    assign res_load  = sar_done && (state == ADCSQ_WAIT);
    // Last channel of the scan group.
    assign scan_last = cur_ch == channel_sel[1:0];
    assign pass_end  = res_load && (scan_last || !scan_mode);
    assign start_clr = pass_end && !scan_mode;

    always_ff @(posedge clk_in) begin
        if (clr_all) begin
            done_irq_enable <= adcsq_pkg::RESET_CTRL_STAT[6];
        end else if (ctrl_wr) begin
            done_irq_enable <= wdata_in[adcsq_pkg::BIT_IRQ_EN];
        end
    end

    always_ff @(posedge clk_in) begin
        if (clr_all) begin
            scan_mode <= adcsq_pkg::RESET_CTRL_STAT[4];
        end else if (ctrl_wr) begin
            scan_mode <= wdata_in[adcsq_pkg::BIT_SCAN];
        end
    end

    always_ff @(posedge clk_in) begin
        if (clr_all) begin
            conversion_speed_sel <= adcsq_pkg::RESET_CTRL_STAT[3];
        end else if (ctrl_wr) begin
            conversion_speed_sel <= wdata_in[adcsq_pkg::BIT_SPEED];
        end
    end

    always_ff @(posedge clk_in) begin
        if (clr_all) begin
            channel_sel <= adcsq_pkg::RESET_CTRL_STAT[2:0];
        end else if (ctrl_wr) begin
            channel_sel <= wdata_in[adcsq_pkg::BIT_GROUP:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (clr_all) begin
            conversion_start <= adcsq_pkg::RESET_CTRL_STAT[5];
        end else if (trig_fall) begin
            conversion_start <= 1'b1;
        end else if (ctrl_wr) begin
            conversion_start <= wdata_in[adcsq_pkg::BIT_START];
        end else if (start_clr) begin
            conversion_start <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (clr_all) begin
            done_seen <= 1'b0;
        end else if (rd_in && hit(addr_in, adcsq_pkg::ADDR_CTRL_STAT)
                     && conversion_done_flag) begin
            done_seen <= 1'b1;
        end else if (!conversion_done_flag) begin
            done_seen <= 1'b0;
        end
    end

    // Done flag: hardware set wins over a software clear in the same cycle.
    always_ff @(posedge clk_in) begin
        if (clr_all) begin
            conversion_done_flag <= adcsq_pkg::RESET_CTRL_STAT[7];
        end else if (pass_end) begin
            conversion_done_flag <= 1'b1;
        end else if (ctrl_wr && !wdata_in[adcsq_pkg::BIT_DONE] && done_seen) begin
            conversion_done_flag <= 1'b0;
        end
    end

    // Trigger control register; low bits are fixed ones.
    always_ff @(posedge clk_in) begin
        if (clr_all) begin
            ext_trigger_enable <= adcsq_pkg::RESET_TRIG_CTRL[7];
        end else if (wr_in && hit(addr_in, adcsq_pkg::ADDR_TRIG_CTRL)) begin
            ext_trigger_enable <= wdata_in[adcsq_pkg::BIT_TRIG_EN];
        end
    end

    // Sequencer: launches each channel and walks the scan group.
    always_ff @(posedge clk_in) begin
        if (clr_all) begin
            state  <= ADCSQ_IDLE;
            cur_ch <= 2'h0;
            sar_go <= 1'b0;
        end else begin
            sar_go <= 1'b0;
            case (state)
                ADCSQ_IDLE: begin
                    if (conversion_start) begin
                        cur_ch <= scan_mode ? 2'h0 : channel_sel[1:0];
                        state  <= ADCSQ_LAUNCH;
                    end
                end
                ADCSQ_LAUNCH: begin
                    sar_go <= 1'b1;
                    state  <= ADCSQ_WAIT;
                end
                ADCSQ_WAIT: begin
                    if (!conversion_start) begin
                        state <= ADCSQ_IDLE;
                    end else if (sar_done) begin
                        if (!scan_mode) begin
                            state <= ADCSQ_IDLE;
                        end else begin
                            cur_ch <= pass_end ? 2'h0 : cur_ch + 2'h1;
                            state  <= ADCSQ_LAUNCH;
                        end
                    end
                end
                default: begin
                    state <= ADCSQ_IDLE;
                end
            endcase
        end
    end

    generate
        for (genvar i = 0; i < 4; i++) begin : g_res
            always_ff @(posedge clk_in) begin
                if (clr_all) begin
                    result_reg[i] <= adcsq_pkg::RESET_RESULT;
                end else if (res_load && cur_ch == 2'(i)) begin
                    result_reg[i] <= sar_result;
                end
            end
        end
    endgenerate

    // Step length per bit for the selected speed.
    assign step_cycles = conversion_speed_sel ? 16'(FAST_CYC / 8)
                                              : 16'(SLOW_CYC / 8);

    adcsq_sar #(
        .BITS (adcsq_pkg::RES_BITS)
    ) u_sar (
        .clk_in         (clk_in),
        .resetn_in      (resetn_in),
        .abort_in       (standby_in || !conversion_start),
        .go_in          (sar_go),
        .step_cycles_in (step_cycles),
        .cmp_in         (cmp_in),
        .trial_out      (sar_trial),
        .done_out       (sar_done),
        .result_out     (sar_result)
    );

    // Front-end outputs, registered.
    // Group bit forms the top bit of the channel index.
    always_ff @(posedge clk_in) begin
        if (clr_all) begin
            mux_sel_out <= 3'h0;
        end else begin
            mux_sel_out <= {channel_sel[2], cur_ch};
        end
    end

    always_ff @(posedge clk_in) begin
        if (clr_all) begin
            dac_trial_out <= 8'h00;
        end else begin
            dac_trial_out <= sar_trial;
        end
    end

    always_ff @(posedge clk_in) begin
        if (clr_all) begin
            conversion_end_irq_out <= 1'b0;
        end else begin
            conversion_end_irq_out <= conversion_done_flag
                                      && done_irq_enable;
        end
    end

    // Status image as software sees it.
    assign csr_image = {conversion_done_flag, done_irq_enable,
                        conversion_start, scan_mode,
                        conversion_speed_sel, channel_sel};

    always_comb begin
        next_rdata = adcsq_pkg::UNMAPPED_READ;
        if (rd_in) begin
            case (addr_in)
                adcsq_pkg::ADDR_RESULT_A: begin
                    next_rdata = result_reg[0];
                end
                adcsq_pkg::ADDR_RESULT_B: begin
                    next_rdata = result_reg[1];
                end
                adcsq_pkg::ADDR_RESULT_C: begin
                    next_rdata = result_reg[2];
                end
                adcsq_pkg::ADDR_RESULT_D: begin
                    next_rdata = result_reg[3];
                end
                adcsq_pkg::ADDR_CTRL_STAT: begin
                    next_rdata = csr_image;
                end
                adcsq_pkg::ADDR_TRIG_CTRL: begin
                    next_rdata = {ext_trigger_enable, 7'h7F};
                end
                default: begin
                    next_rdata = adcsq_pkg::UNMAPPED_READ;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rdata_out <= adcsq_pkg::UNMAPPED_READ;
        end else begin
            rdata_out <= next_rdata;
        end
    end
endmodule

// ===== dv/adcsq_front_checker.sv
// Port-level assertions for the converter control block.
`timescale 1ns/1ps
module adcsq_front_checker #(
    parameter int SLOW_CYC = adcsq_pkg::SLOW_CYCLES,
    parameter int FAST_CYC = adcsq_pkg::FAST_CYCLES
) (
    input wire logic        clk_in,
    input wire logic        resetn_in,
    input wire logic        standby_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0]  wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [7:0]  rdata_out,
    input wire logic        cmp_in,
    input wire logic [2:0]  mux_sel_out,
    input wire logic [7:0]  dac_trial_out,
    input wire logic        ext_start_trigger_n_in,
    input wire logic        conversion_end_irq_out
);
    logic [7:0] low_bit;
    logic       mapped;
    logic       new_step;
    // Lowest set bit of the trial code marks the bit under test.
    assign low_bit  = dac_trial_out & (~dac_trial_out + 8'h01);
    assign mapped   = addr_in[15:4] == 12'hFFE && !addr_in[0]
                      && addr_in[3:0] <= 4'hA;
    assign new_step = dac_trial_out != 8'h00 && dac_trial_out != 8'h80;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    property p_rd_idle;
        !rd_in |=> rdata_out == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    property p_unmapped;
        rd_in && !mapped |=> rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_trig_rsvd;
        rd_in && addr_in == adcsq_pkg::ADDR_TRIG_CTRL
        |=> rdata_out[6:0] == 7'h7F;
    endproperty
    a_trig_rsvd: assert property (p_trig_rsvd)
        else $error("reserved trigger bits not one");
    property p_irq_gate;
        rd_in && !standby_in && addr_in == adcsq_pkg::ADDR_CTRL_STAT
        |=> conversion_end_irq_out == (rdata_out[7] & rdata_out[6]);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt differs from flag and enable");
    property p_sar_step;
        $changed(dac_trial_out) && $past(dac_trial_out) != 8'h00
        && $past(low_bit) != 8'h01 && new_step
        |-> low_bit == ($past(low_bit) >> 1);
    endproperty
    a_sar_step: assert property (p_sar_step)
        else $error("trial skipped a bit");
    property p_step_hold;
        $changed(dac_trial_out) && dac_trial_out != 8'h00
        && $past(low_bit) != 8'h01
        |=> ($stable(dac_trial_out) || dac_trial_out == 8'h00) [*3];
    endproperty
    a_step_hold: assert property (p_step_hold)
        else $error("trial step too short");
    property p_mux_hold;
        $changed(dac_trial_out) && new_step && $past(low_bit) != 8'h01
        |-> $stable(mux_sel_out);
    endproperty
    a_mux_hold: assert property (p_mux_hold)
        else $error("channel changed inside conversion");
    property p_irq_standby;
        standby_in [*2] |=> !conversion_end_irq_out;
    endproperty
    a_irq_standby: assert property (p_irq_standby)
        else $error("interrupt survives standby");
endmodule
bind adcsq_top adcsq_front_checker #(
    .SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) adcsq_front_checker_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .standby_in(standby_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .cmp_in(cmp_in), .mux_sel_out(mux_sel_out),
    .dac_trial_out(dac_trial_out),
    .ext_start_trigger_n_in(ext_start_trigger_n_in),
    .conversion_end_irq_out(conversion_end_irq_out));

// ===== dv/adcsq_analog_model.sv
// Analog front end model: one fixed level per input and a comparator.
`timescale 1ns/1ps
module adcsq_analog_model #(
    parameter logic [63:0] LEVELS = 64'h0
) (
    // Selection from the converter.
    input  wire logic [2:0] mux_sel_in,
    input  wire logic [7:0] trial_in,
    // Comparator answer.
    output logic            cmp_out
);
    logic [7:0] level;
    assign level = LEVELS[mux_sel_in * 8 +: 8];
    assign cmp_out = level >= trial_in;
endmodule

// ===== dv/adcsq_top_test.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module adcsq_top_test;
    localparam int SLOW_C = 64;
    localparam int FAST_C = 32;
    localparam logic [63:0] LVL = 64'hA53C7F80FF01C35A;
    localparam logic [15:0] CSR = adcsq_pkg::ADDR_CTRL_STAT;
    localparam logic [15:0] TRG = adcsq_pkg::ADDR_TRIG_CTRL;
    logic        clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        standby_in = 1'b0;
    logic [15:0] addr_in = 16'h0000;
    logic [7:0]  wdata_in = 8'h00;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic        trig_n = 1'b1;
    logic [7:0]  rdata_out;
    logic        cmp_in;
    logic [2:0]  mux_sel_out;
    logic [7:0]  dac_trial_out;
    logic        irq;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    adcsq_top #(.SLOW_CYC(SLOW_C), .FAST_CYC(FAST_C)) adcsq_top_i (
        .clk_in(clk_in), .resetn_in(resetn_in), .standby_in(standby_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .cmp_in(cmp_in),
        .mux_sel_out(mux_sel_out), .dac_trial_out(dac_trial_out),
        .ext_start_trigger_n_in(trig_n), .conversion_end_irq_out(irq));
    adcsq_analog_model #(.LEVELS(LVL)) adcsq_analog_model_i (
        .mux_sel_in(mux_sel_out), .trial_in(dac_trial_out),
        .cmp_out(cmp_in));
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= v;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1 v = rdata_out;
    endtask
    task automatic rdchk(input string what, input logic [15:0] a,
                         input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(what, exp, v);
    endtask
    task automatic irq_is(input logic exp);
        repeat (2) @(posedge clk_in);
        #1 chk("interrupt", {7'h00, exp}, {7'h00, irq});
    endtask
    task automatic wait_done(output int n, output logic [7:0] v);
        n = 0;
        v = 8'h00;
        while (v[7] !== 1'b1 && n < 4 * SLOW_C) begin
            rd(CSR, v);
            n += 2;
        end
    endtask
    task automatic check_map;
        for (int i = 0; i < 7; i++) begin
            rdchk("map", 16'hFFE0 + 16'(2 * i), i == 5 ? 8'h7F : 8'h00);
        end
    endtask
    task automatic pulse;
        @(posedge clk_in);
        trig_n <= 1'b0;
        repeat (4) @(posedge clk_in);
        trig_n <= 1'b1;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic single(input int ch, input logic fast);
        int n;
        int t;
        logic [7:0] v;
        logic [7:0] c;
        t = fast ? FAST_C : SLOW_C;
        c = {4'h2, fast, 3'(ch)};
        wr(CSR, c);
        wait_done(n, v);
        chk("time", 8'(n >= t - 4 && n <= t + 16), 8'h01);
        chk("single end", c ^ 8'hA0, v);
        chk("irq off", 8'h00, {7'h00, irq});
        rdchk("result", 16'hFFE0 + 16'(2 * (ch % 4)),
              LVL[ch * 8 +: 8]);
        wr(CSR, c & 8'h1F);
        rdchk("flag clear", CSR, c & 8'h1F);
    endtask
    initial begin
        int n;
        logic [7:0] d;
        repeat (8) @(posedge clk_in);
        resetn_in <= 1'b1;
        check_map();
        wr(adcsq_pkg::ADDR_RESULT_A, 8'hAA);
        rdchk("read only", adcsq_pkg::ADDR_RESULT_A, 8'h00);
        wr(TRG, 8'h80);
        rdchk("trig ctrl", TRG, 8'hFF);
        wr(TRG, 8'h00);
        for (int ch = 0; ch < 8; ch++) single(ch, 1'b1);
        single(5, 1'b0);
        wr(CSR, 8'h69);
        for (n = 0; n < 4 * SLOW_C && irq !== 1'b1; n++) @(posedge clk_in);
        rdchk("result b", adcsq_pkg::ADDR_RESULT_B, 8'hC3);
        wr(CSR, 8'h49);
        irq_is(1'b1);
        wr(CSR, 8'h89);
        irq_is(1'b0);
        wr(CSR, 8'hC9);
        irq_is(1'b1);
        rdchk("flag kept", CSR, 8'hC9);
        wr(CSR, 8'h49);
        irq_is(1'b0);
        wr(CSR, 8'hC9);
        rdchk("one ignored", CSR, 8'h49);
        wr(CSR, 8'h3E);
        wait_done(n, d);
        chk("scan pass", 8'(n >= 3 * FAST_C - 4), 8'h01);
        chk("scan runs", 8'hBE, d);
        for (int i = 0; i < 4; i++) begin
            rdchk("scan result", 16'hFFE0 + 16'(2 * i),
                  LVL[(i + 4) * 8 +: 8]);
        end
        wr(CSR, 8'h3E);
        wait_done(n, d);
        chk("scan again", 8'hBE, d);
        wr(CSR, 8'h1E);
        repeat (3 * FAST_C) @(posedge clk_in);
        rdchk("scan stop", CSR, 8'h1E);
        wr(CSR, 8'h0A);
        pulse();
        repeat (3 * FAST_C) @(posedge clk_in);
        rdchk("trig off", CSR, 8'h0A);
        wr(TRG, 8'h80);
        pulse();
        wait_done(n, d);
        chk("trig start", 8'h8A, d);
        rdchk("result c", adcsq_pkg::ADDR_RESULT_C, 8'h01);
        wr(CSR, 8'hCA);
        standby_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        standby_in <= 1'b0;
        check_map();
        irq_is(1'b0);
        wr(CSR, 8'h3E);
        repeat (20) @(posedge clk_in);
        resetn_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        check_map();
        give_verdict();
    end
endmodule
